// ---- design/gp_timer_pkg.sv ----
// Constants, register map and field layout for the general purpose timers
package gp_timer_pkg;

  localparam int NUM_TIMERS = 5;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;

  // Timer slots
  localparam int T_SINGLE = 0;
  localparam int A_LO = 1;
  localparam int A_HI = 2;
  localparam int B_LO = 3;
  localparam int B_HI = 4;

  // Register indices
  localparam logic [4:0] REG_SINGLE_CONTROL = 5'h00;
  localparam logic [4:0] REG_SINGLE_COUNT = 5'h01;
  localparam logic [4:0] REG_SINGLE_PERIOD = 5'h02;
  localparam logic [4:0] REG_PAIR_A_BASE = 5'h03;
  localparam logic [4:0] REG_PAIR_B_BASE = 5'h0a;
  localparam logic [4:0] REG_FLAGS = 5'h11;

  // Offsets inside one pair
  localparam logic [4:0] OFS_LOW_CONTROL = 5'h00;
  localparam logic [4:0] OFS_HIGH_CONTROL = 5'h01;
  localparam logic [4:0] OFS_COUNT_LOW = 5'h02;
  localparam logic [4:0] OFS_COUNT_HIGH = 5'h03;
  localparam logic [4:0] OFS_PERIOD_LOW = 5'h04;
  localparam logic [4:0] OFS_PERIOD_HIGH = 5'h05;
  localparam logic [4:0] OFS_HIGH_HOLD = 5'h06;

  // Control field positions
  localparam int BIT_ON = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_GATE = 6;
  localparam int PRESCALE_MSB = 5;
  localparam int PRESCALE_LSB = 4;
  localparam int BIT_WIDE = 3;
  localparam int BIT_SYNC = 2;
  localparam int BIT_CLK_SRC = 1;

  // Implemented bits of each control register
  localparam logic [15:0] SINGLE_CONTROL_MASK = 16'ha076;
  localparam logic [15:0] LOW_CONTROL_MASK = 16'ha07a;
  localparam logic [15:0] HIGH_CONTROL_MASK = 16'ha072;

  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  // Last prescale count for 1:1, 1:8, 1:64, 1:256
  function automatic logic [7:0] prescale_last(input logic [1:0] sel);
    case (sel)
      2'h0: prescale_last = 8'h00;
      2'h1: prescale_last = 8'h07;
      2'h2: prescale_last = 8'h3f;
      default: prescale_last = 8'hff;
    endcase
  endfunction

endpackage

// ---- design/gp_timers.sv ----
// One single timer and two joinable timer pairs behind a plain register port
`timescale 1ns/100ps

module gp_timers
  import gp_timer_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  input wire logic IDLE,
  input wire logic [NUM_TIMERS-1:0] PINS,
  output logic [NUM_TIMERS-1:0] FLAGS,
  output logic ADC_TRIGGER
);

  // Pin synchronisers and filtered levels
  logic [NUM_TIMERS-1:0] s1;
  logic [NUM_TIMERS-1:0] s2;
  logic [NUM_TIMERS-1:0] s3;
  logic [NUM_TIMERS-1:0] lvl;
  logic [NUM_TIMERS-1:0] lvl_d;
  logic [NUM_TIMERS-1:0] next_s1;
  logic [NUM_TIMERS-1:0] next_s2;
  logic [NUM_TIMERS-1:0] next_s3;
  logic [NUM_TIMERS-1:0] next_lvl;
  logic [NUM_TIMERS-1:0] next_lvl_d;

  // Half-rate internal clock enable
  logic half;
  logic next_half;

  // Timer state
  logic [15:0] con [NUM_TIMERS];
  logic [15:0] cnt [NUM_TIMERS];
  logic [15:0] per [NUM_TIMERS];
  logic [7:0] pre [NUM_TIMERS];
  logic [15:0] next_con [NUM_TIMERS];
  logic [15:0] next_cnt [NUM_TIMERS];
  logic [15:0] next_per [NUM_TIMERS];
  logic [7:0] next_pre [NUM_TIMERS];
  logic [15:0] hold [2];
  logic [15:0] next_hold [2];
  logic [NUM_TIMERS-1:0] flag;
  logic [NUM_TIMERS-1:0] next_flag;
  logic [DATA_W-1:0] next_rdata;
  logic adc;
  logic next_adc;

  always_comb begin
    logic [NUM_TIMERS-1:0] agree;

    agree = ~(s2 ^ s3);
    next_s1 = PINS;
    next_s2 = s1;
    next_s3 = s2;
    next_lvl = (agree & s2) | (~agree & lvl);
    next_lvl_d = lvl;
    next_half = ~half;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      lvl <= '0;
      lvl_d <= '0;
      half <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      lvl <= next_lvl;
      lvl_d <= next_lvl_d;
      half <= next_half;
    end
  end

  always_comb begin
    logic [NUM_TIMERS-1:0] rise;
    logic [NUM_TIMERS-1:0] fall;
    logic [NUM_TIMERS-1:0] gated;
    logic [NUM_TIMERS-1:0] run;
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] hit;
    logic [NUM_TIMERS-1:0] gfall;
    logic [NUM_TIMERS-1:0] set;
    logic [NUM_TIMERS-1:0] clear;
    logic [1:0] wide;
    logic [1:0] hit32;
    logic [31:0] cnt32;
    logic [4:0] base;
    logic [4:0] ofs;
    logic ext;
    logic asyn;
    logic slave;
    logic raw;
    logic skip;
    logic stop_idle;
    logic [7:0] last;
    int l;
    int h;

    rise = lvl & ~lvl_d;
    fall = ~lvl & lvl_d;
    gated = '0;
    run = '0;
    tick = '0;
    hit = '0;
    gfall = '0;
    set = '0;
    clear = '0;
    hit32 = '0;
    cnt32 = '0;
    base = '0;
    ofs = '0;
    ext = 1'b0;
    asyn = 1'b0;
    slave = 1'b0;
    raw = 1'b0;
    skip = 1'b0;
    stop_idle = 1'b0;
    last = 8'h00;
    l = 0;
    h = 0;
    wide = {con[B_LO][BIT_WIDE], con[A_LO][BIT_WIDE]};
    next_con = con;
    next_cnt = cnt;
    next_per = per;
    next_pre = pre;
    next_hold = hold;
    next_rdata = '0;

    // Count clock, gating and prescaler per timer
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ext = con[i][BIT_CLK_SRC];
      gated[i] = !ext && con[i][BIT_GATE];
      asyn = (i == T_SINGLE) && ext && !con[i][BIT_SYNC];
      stop_idle = IDLE && con[i][BIT_IDLE_HALT] && !asyn;
      run[i] = con[i][BIT_ON] && !stop_idle;
      slave = (i == A_HI && wide[0]) || (i == B_HI && wide[1]);
      if (slave) begin
        run[i] = 1'b0;
      end
      raw = ext ? rise[i] : (half && (!gated[i] || lvl[i]));
      last = prescale_last(con[i][PRESCALE_MSB:PRESCALE_LSB]);
      if (run[i] && raw) begin
        if (pre[i] >= last) begin
          next_pre[i] = 8'h00;
          tick[i] = 1'b1;
        end else begin
          next_pre[i] = pre[i] + 8'h01;
        end
      end
      gfall[i] = run[i] && gated[i] && fall[i];
    end

    // Sixteen-bit counting
    for (int i = 0; i < NUM_TIMERS; i++) begin
      skip = (i == A_LO && wide[0]) || (i == B_LO && wide[1]);
      if (tick[i] && !skip) begin
        if (cnt[i] == per[i]) begin
          next_cnt[i] = 16'h0000;
          hit[i] = 1'b1;
        end else begin
          next_cnt[i] = cnt[i] + 16'h0001;
        end
      end
      set[i] = (hit[i] && !gated[i]) || gfall[i];
    end

    // Joined pairs
    for (int p = 0; p < 2; p++) begin
      l = (p == 0) ? A_LO : B_LO;
      h = (p == 0) ? A_HI : B_HI;
      if (wide[p]) begin
        cnt32 = {cnt[h], cnt[l]};
        if (tick[l]) begin
          if (cnt32 == {per[h], per[l]}) begin
            cnt32 = 32'h00000000;
            hit32[p] = 1'b1;
          end else begin
            cnt32 = cnt32 + 32'h00000001;
          end
        end
        next_cnt[h] = cnt32[31:16];
        next_cnt[l] = cnt32[15:0];
        set[l] = 1'b0;
        set[h] = (hit32[p] && !gated[l]) || gfall[l];
      end
    end

    next_adc = wide[0] ? hit32[0] : hit[A_HI];

    // Register writes
    if (WR) begin
      case (ADDR)
        REG_SINGLE_CONTROL: begin
          next_con[T_SINGLE] = WDATA & SINGLE_CONTROL_MASK;
          if (con[T_SINGLE][BIT_ON]) begin
            next_pre[T_SINGLE] = 8'h00;
          end
        end
        REG_SINGLE_COUNT: next_cnt[T_SINGLE] = WDATA;
        REG_SINGLE_PERIOD: next_per[T_SINGLE] = WDATA;
        REG_FLAGS: clear = WDATA[NUM_TIMERS-1:0];
        default: begin
        end
      endcase
      for (int p = 0; p < 2; p++) begin
        l = (p == 0) ? A_LO : B_LO;
        h = (p == 0) ? A_HI : B_HI;
        base = (p == 0) ? REG_PAIR_A_BASE : REG_PAIR_B_BASE;
        ofs = ADDR - base;
        if (ADDR >= base) begin
          case (ofs)
            OFS_LOW_CONTROL: begin
              next_con[l] = WDATA & LOW_CONTROL_MASK;
              if (con[l][BIT_ON]) begin
                next_pre[l] = 8'h00;
              end
            end
            OFS_HIGH_CONTROL: begin
              next_con[h] = WDATA & HIGH_CONTROL_MASK;
              if (con[h][BIT_ON]) begin
                next_pre[h] = 8'h00;
              end
            end
            OFS_COUNT_LOW: begin
              next_cnt[l] = WDATA;
              if (wide[p]) begin
                next_cnt[h] = hold[p];
              end
            end
            OFS_COUNT_HIGH: next_cnt[h] = WDATA;
            OFS_PERIOD_LOW: next_per[l] = WDATA;
            OFS_PERIOD_HIGH: next_per[h] = WDATA;
            OFS_HIGH_HOLD: next_hold[p] = WDATA;
            default: begin
            end
          endcase
        end
      end
    end

    // Register reads, answered one cycle later
    if (RD) begin
      case (ADDR)
        REG_SINGLE_CONTROL: next_rdata = con[T_SINGLE];
        REG_SINGLE_COUNT: next_rdata = cnt[T_SINGLE];
        REG_SINGLE_PERIOD: next_rdata = per[T_SINGLE];
        REG_FLAGS: next_rdata = {11'h000, flag};
        default: begin
        end
      endcase
      for (int p = 0; p < 2; p++) begin
        l = (p == 0) ? A_LO : B_LO;
        h = (p == 0) ? A_HI : B_HI;
        base = (p == 0) ? REG_PAIR_A_BASE : REG_PAIR_B_BASE;
        ofs = ADDR - base;
        if (ADDR >= base) begin
          case (ofs)
            OFS_LOW_CONTROL: next_rdata = con[l];
            OFS_HIGH_CONTROL: next_rdata = con[h];
            OFS_COUNT_LOW: begin
              next_rdata = cnt[l];
              if (wide[p]) begin
                next_hold[p] = cnt[h];
              end
            end
            OFS_COUNT_HIGH: next_rdata = cnt[h];
            OFS_PERIOD_LOW: next_rdata = per[l];
            OFS_PERIOD_HIGH: next_rdata = per[h];
            OFS_HIGH_HOLD: next_rdata = hold[p];
            default: begin
            end
          endcase
        end
      end
    end

    // Hardware set wins over software clear
    next_flag = (flag & ~clear) | set;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        con[i] <= CONTROL_RESET;
        cnt[i] <= COUNT_RESET;
        per[i] <= PERIOD_RESET;
        pre[i] <= 8'h00;
      end
      hold[0] <= COUNT_RESET;
      hold[1] <= COUNT_RESET;
      flag <= '0;
      RDATA <= '0;
      adc <= 1'b0;
    end else begin
      con <= next_con;
      cnt <= next_cnt;
      per <= next_per;
      pre <= next_pre;
      hold <= next_hold;
      flag <= next_flag;
      RDATA <= next_rdata;
      adc <= next_adc;
    end
  end

  assign FLAGS = flag;
  assign ADC_TRIGGER = adc;

endmodule

// ---- testbench/pin_model.sv ----
// Far-side driver for the timer clock and gate pins
`timescale 1ns/100ps
module pin_model (
  input wire logic CLK,
  input wire logic go,
  input wire logic [7:0] half,
  input wire logic [4:0] mask,
  output logic [4:0] PINS
);
  logic [7:0] cnt = 8'h00;
  logic lvl = 1'b0;
  // Square wave while enabled, pins low and still otherwise
  always @(posedge CLK) begin
    if (!go) begin
      cnt <= 8'h00;
      lvl <= 1'b0;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign PINS = lvl ? mask : 5'h00;
endmodule

// ---- testbench/gp_timers_asserts.sv ----
// Port assertions for the general purpose timers
`timescale 1ns/100ps
module gp_timers_asserts
  import gp_timer_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic IDLE,
  input wire logic [NUM_TIMERS-1:0] PINS,
  input wire logic [NUM_TIMERS-1:0] FLAGS,
  input wire logic ADC_TRIGGER
);
  logic [15:0] ctl;
  logic wide;
  logic halt;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Shadow of single control and pair A join bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctl <= CONTROL_RESET;
      wide <= 1'b0;
    end else if (WR && ADDR == REG_SINGLE_CONTROL) begin
      ctl <= WDATA;
    end else if (WR && ADDR == REG_PAIR_A_BASE) begin
      wide <= WDATA[BIT_WIDE];
    end
  end
  assign halt = IDLE && ctl[BIT_IDLE_HALT] && !(ctl[BIT_CLK_SRC] && !ctl[BIT_SYNC]);
  property p_rdata_gap;
    !RD |=> RDATA == 16'h0000;
  endproperty
  a_rdata_gap: assert property (p_rdata_gap) else $error("read data outside answer");
  property p_single_mask;
    RD && ADDR == REG_SINGLE_CONTROL |=> (RDATA & ~SINGLE_CONTROL_MASK) == 16'h0000;
  endproperty
  a_single_mask: assert property (p_single_mask) else $error("unused bit set");
  property p_high_mask;
    RD && ADDR == REG_PAIR_A_BASE + OFS_HIGH_CONTROL |=> (RDATA & ~HIGH_CONTROL_MASK) == 16'h0;
  endproperty
  a_high_mask: assert property (p_high_mask) else $error("high control bit set");
  property p_sticky;
    !(WR && ADDR == REG_FLAGS) |=> (FLAGS & $past(FLAGS)) == $past(FLAGS);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_adc_pulse;
    ADC_TRIGGER |=> !ADC_TRIGGER;
  endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("trigger too long");
  property p_wide_low;
    $past(wide) |-> !$rose(FLAGS[A_LO]);
  endproperty
  a_wide_low: assert property (p_wide_low) else $error("low flag in wide mode");
  property p_off;
    !$past(ctl[BIT_ON]) |-> !$rose(FLAGS[T_SINGLE]);
  endproperty
  a_off: assert property (p_off) else $error("flag while off");
  property p_idle;
    $past(halt) |-> !$rose(FLAGS[T_SINGLE]);
  endproperty
  a_idle: assert property (p_idle) else $error("flag while halted");
  cover property (ADC_TRIGGER && wide);
  cover property ($rose(FLAGS[T_SINGLE]));
  cover property (halt && ctl[BIT_ON]);
endmodule

// ---- testbench/gp_timers_test.sv ----
// Self-checking testbench for the general purpose timers
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
module gp_timers_test;
  import gp_timer_pkg::*;
  logic CLK = 0, RST = 1, WR = 0, RD = 0, IDLE = 0, go = 0, ADC_TRIGGER;
  logic [4:0] ADDR = 0, PINS, FLAGS, mask = 0;
  logic [15:0] WDATA = 0, RDATA, rv, p;
  logic [7:0] half = 8'h04;
  int bad_count = 0, num_checks = 0, adc_n = 0, n, s;
  logic [4:0] ctl_at[5] = '{5'h00, 5'h03, 5'h04, 5'h0a, 5'h0b};
  logic [4:0] per_at[5] = '{5'h02, 5'h07, 5'h08, 5'h0e, 5'h0f};
  logic [15:0] msk[5] = '{SINGLE_CONTROL_MASK, LOW_CONTROL_MASK, HIGH_CONTROL_MASK,
    LOW_CONTROL_MASK, HIGH_CONTROL_MASK};
  gp_timers DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IDLE(IDLE), .PINS(PINS), .FLAGS(FLAGS), .ADC_TRIGGER(ADC_TRIGGER));
  pin_model PM (.CLK(CLK), .go(go), .half(half), .mask(mask), .PINS(PINS));
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) if (ADC_TRIGGER) adc_n++;
  function automatic int period_cycles(input int code, input logic [15:0] per);
    return 2 * (code == 3 ? 256 : 1 << (3 * code)) * (int'(per) + 1);
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    @(posedge CLK);
  endtask
  task automatic wait_flag(input int b, input int lim);
    n = 0;
    while (FLAGS[b] !== 1'b1 && n < lim) begin
      @(posedge CLK);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  endtask
  initial begin
    void'($urandom(32'h245e91e2));
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(5'h02, rv);
    `CHK(rv, PERIOD_RESET)
    rd(5'h1f, rv);
    `CHK(rv, 16'h0000)
    for (s = 0; s < 5; s++) begin
      rd(ctl_at[s], rv);
      `CHK(rv, CONTROL_RESET)
      p = 16'($urandom()) & 16'h7fff;
      wr(ctl_at[s], p);
      rd(ctl_at[s], rv);
      `CHK(rv, p & msk[s])
      wr(ctl_at[s], 16'h0000);
    end
    for (s = 0; s < 5; s++) begin
      p = 16'($urandom_range(4, 1));
      wr(per_at[s], p);
      wr(ctl_at[s], 16'h8000 | 16'((s % 4) << PRESCALE_LSB));
      adc_n = 0;
      wait_flag(s, 9000);
      wr(REG_FLAGS, 16'h001f);
      wait_flag(s, 9000);
      `CHK(n + 2, period_cycles(s % 4, p))
      wr(ctl_at[s], 16'h0000);
      `CHK(adc_n, (s == A_HI) ? 2 : 0)
      wr(REG_FLAGS, 16'h001f);
    end
    wr(5'h03, 16'h0008);
    wr(5'h09, 16'h0000);
    wr(5'h05, 16'hfffe);
    wr(5'h08, 16'h0001);
    wr(5'h07, 16'h0005);
    adc_n = 0;
    wr(5'h03, 16'h8008);
    repeat (10) @(posedge CLK);
    wr(5'h03, 16'h0008);
    rd(5'h05, rv);
    `CHK(rv, 16'h0004)
    rd(5'h09, rv);
    `CHK(rv, 16'h0001)
    rd(5'h06, rv);
    `CHK(rv, 16'h0001)
    `CHK(FLAGS, 5'h00)
    wr(5'h03, 16'h8008);
    wait_flag(A_HI, 200);
    wr(5'h03, 16'h0000);
    `CHK(FLAGS[A_LO], 1'b0)
    `CHK(adc_n, 1)
    wr(REG_FLAGS, 16'h001f);
    wr(5'h02, 16'hffff);
    wr(5'h00, 16'h8040);
    mask <= 5'h01;
    half <= 8'd20;
    go <= 1'b1;
    repeat (30) @(posedge CLK);
    `CHK(FLAGS[T_SINGLE], 1'b0)
    go <= 1'b0;
    wait_flag(T_SINGLE, 20);
    wr(5'h00, 16'h0000);
    rd(5'h01, rv);
    `CHK(rv > 16'h0002 && rv < 16'h0008, 1'b1)
    for (s = 0; s < 2; s++) begin
      wr(REG_FLAGS, 16'h001f);
      wr(5'h01, 16'h0000);
      wr(5'h02, 16'h0003);
      wr(5'h00, s ? 16'h8042 : 16'h8046);
      half <= 8'd4;
      go <= 1'b1;
      repeat (23) @(posedge CLK);
      `CHK(FLAGS[T_SINGLE], 1'b0)
      wait_flag(T_SINGLE, 20);
      go <= 1'b0;
      wr(5'h00, 16'h0000);
    end
    wr(REG_FLAGS, 16'h001f);
    IDLE <= 1'b1;
    wr(5'h01, 16'h0000);
    wr(5'h00, 16'ha042);
    go <= 1'b1;
    wait_flag(T_SINGLE, 60);
    go <= 1'b0;
    wr(5'h00, 16'h0000);
    wr(REG_FLAGS, 16'h001f);
    wr(5'h01, 16'h0000);
    wr(5'h00, 16'ha046);
    go <= 1'b1;
    repeat (40) @(posedge CLK);
    `CHK(FLAGS[T_SINGLE], 1'b0)
    go <= 1'b0;
    wr(5'h00, 16'h0000);
    wr(REG_FLAGS, 16'h001f);
    wr(5'h02, 16'h0000);
    wr(5'h00, 16'ha000);
    repeat (20) @(posedge CLK);
    `CHK(FLAGS[T_SINGLE], 1'b0)
    IDLE <= 1'b0;
    wait_flag(T_SINGLE, 10);
    wr(5'h00, 16'h0000);
    wr(REG_FLAGS, 16'h001f);
    wr(5'h01, 16'h0000);
    wr(5'h00, 16'h8030);
    repeat (300) @(posedge CLK);
    wr(5'h00, 16'h8030);
    repeat (300) @(posedge CLK);
    `CHK(FLAGS[T_SINGLE], 1'b0)
    wait_flag(T_SINGLE, 300);
    finish_test();
  end
endmodule
bind gp_timers gp_timers_asserts CHECK (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .IDLE(IDLE), .PINS(PINS), .FLAGS(FLAGS),
  .ADC_TRIGGER(ADC_TRIGGER));
